// *** rtl/gal_regs.sv ***
`default_nettype none
// Register bank for the two auxiliary pins, write lock and identity codes.
// Avalon-MM slave: byte address = 4 * register index; one wait state per access.
module gal_regs #(
	parameter logic [7:0] PART_CODE = gal_pkg::GAL_PART_MULTI
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] avs_response,
	input wire logic aux_pin_a,
	input wire logic aux_pin_b,
	input wire logic [2:0] shutdown_config_code,
	output logic alert_n,
	output logic gpio_event
);
	logic ack_q;
	logic [1:0] dir_q;
	logic [1:0] alert_en_q;
	logic [1:0] flags_q;
	logic lock_q;
	logic [1:0] sync1_q;
	logic [1:0] sync2_q;
	logic [1:0] prev_q;
	logic [1:0] change;
	logic [1:0] alert_q;
	logic [2:0] feat_q;
	logic [7:0] idx;
	logic wr_go;
	logic rd_go;
	logic wr_lo;
	logic hit;
	logic [7:0] rd_val;

	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == gal_pkg::GAL_IDX_DIR) || (i == gal_pkg::GAL_IDX_ALERT_EN) ||
			(i == gal_pkg::GAL_IDX_FLAGS) || (i == gal_pkg::GAL_IDX_LOCK) ||
			(i == gal_pkg::GAL_IDX_FEAT) || (i == gal_pkg::GAL_IDX_PART) ||
			(i == gal_pkg::GAL_IDX_MAKER) || (i == gal_pkg::GAL_IDX_REV);
	endfunction : is_mapped

	assign idx = avs_address[9:2];
	assign hit = is_mapped(idx);
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign wr_go = avs_write & ack_q;
	assign rd_go = avs_read & ack_q;
	assign wr_lo = wr_go & avs_byteenable[0];

	// The answer comes one cycle after the request is seen.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read | avs_write) & ~ack_q;
		end
	end

	// Lockable registers: direction, alert enable and the lock itself.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dir_q <= gal_pkg::GAL_RST_DIR;
			alert_en_q <= gal_pkg::GAL_RST_ALERT_EN;
			lock_q <= gal_pkg::GAL_RST_LOCK;
		end else if (wr_lo && !lock_q) begin
			if (idx == gal_pkg::GAL_IDX_DIR) begin
				dir_q <= avs_writedata[1:0];
			end
			if (idx == gal_pkg::GAL_IDX_ALERT_EN) begin
				alert_en_q <= avs_writedata[1:0];
			end
			if (idx == gal_pkg::GAL_IDX_LOCK) begin
				lock_q <= avs_writedata[gal_pkg::GAL_BIT_LOCK];
			end
		end
	end

	// Pins are synchronised before edge detection; the first stage feeds only the second.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_q <= 2'h0;
			sync2_q <= 2'h0;
			prev_q <= 2'h0;
		end else begin
			sync1_q <= {aux_pin_b, aux_pin_a};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Changes count only on pins set as inputs.
	assign change = (sync2_q ^ prev_q) & ~dir_q;

	// A change in the same cycle as the clearing read survives it.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= gal_pkg::GAL_RST_FLAGS;
		end else if (rd_go && idx == gal_pkg::GAL_IDX_FLAGS) begin
			flags_q <= change;
		end else begin
			flags_q <= flags_q | change;
		end
	end

	// Alert latches per pin until cleared by the flag read, disabled, or its pin set as an output.
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			alert_q <= 2'h0;
		end else if (rd_go && idx == gal_pkg::GAL_IDX_FLAGS) begin
			alert_q <= change & alert_en_q & ~dir_q;
		end else begin
			alert_q <= (alert_q | (change & alert_en_q)) & alert_en_q & ~dir_q;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			feat_q <= 3'h0;
		end else begin
			feat_q <= shutdown_config_code;
		end
	end

	assign alert_n = ~|alert_q;
	assign gpio_event = |flags_q;

	always_comb begin
		rd_val = 8'h00;
		case (idx)
			gal_pkg::GAL_IDX_DIR: rd_val = {6'h00, dir_q};
			gal_pkg::GAL_IDX_ALERT_EN: rd_val = {6'h00, alert_en_q};
			gal_pkg::GAL_IDX_FLAGS: rd_val = {6'h00, flags_q};
			gal_pkg::GAL_IDX_LOCK: rd_val = {7'h00, lock_q};
			gal_pkg::GAL_IDX_FEAT: rd_val = {5'h00, feat_q};
			gal_pkg::GAL_IDX_PART: rd_val = PART_CODE;
			gal_pkg::GAL_IDX_MAKER: rd_val = gal_pkg::GAL_MAKER_CODE;
			gal_pkg::GAL_IDX_REV: rd_val = gal_pkg::GAL_REV_CODE;
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end else if ((avs_read | avs_write) && !ack_q) begin
			avs_readdata <= {24'h000000, rd_val};
			avs_response <= hit ? 2'h0 : 2'h3;
		end
	end

	a_lock_sticky: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(lock_q) |-> lock_q) else $error("lock cleared after set");
	a_lock_freezes_en: assert property (@(posedge mclk) disable iff (!arst_n)
		$past(lock_q) |-> $stable(alert_en_q) && $stable(dir_q)) else $error("locked register changed");
	a_flag_holds: assert property (@(posedge mclk) disable iff (!arst_n)
		(flags_q[0] && !(rd_go && idx == gal_pkg::GAL_IDX_FLAGS)) |=> flags_q[0]) else $error("flag lost");
	a_flag_on_change: assert property (@(posedge mclk) disable iff (!arst_n)
		change[1] |=> flags_q[1]) else $error("change not flagged");
	a_read_clears: assert property (@(posedge mclk) disable iff (!arst_n)
		(rd_go && idx == gal_pkg::GAL_IDX_FLAGS && change == 2'h0) |=> flags_q == 2'h0)
		else $error("read did not clear");
	a_event_summary: assert property (@(posedge mclk) disable iff (!arst_n)
		gpio_event == (flags_q != 2'h0)) else $error("summary mismatch");
	a_alert_cause: assert property (@(posedge mclk) disable iff (!arst_n)
		(change[0] && alert_en_q[0] && !dir_q[0] && !rd_go) |=> !alert_n) else $error("alert missing");
	a_output_no_alert: assert property (@(posedge mclk) disable iff (!arst_n)
		dir_q[1] |=> !alert_q[1]) else $error("output pin alerted");
	a_one_wait: assert property (@(posedge mclk) disable iff (!arst_n)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait timing");
	c_flag_read: cover property (@(posedge mclk) disable iff (!arst_n) rd_go && flags_q != 2'h0);
	c_lock_set: cover property (@(posedge mclk) disable iff (!arst_n) $rose(lock_q));
	c_alert: cover property (@(posedge mclk) disable iff (!arst_n) $fell(alert_n));
endmodule : gal_regs
`default_nettype wire

// *** shared/gal_pkg.sv ***
// Function
// - Enabled input pin change asserts alert output
// - Output pins never raise alerts
// - Enable bits: pin b bit1, a bit0
// - Change flags reset zero, clear on read
// - Flags set regardless of alert enable
// - Set flags stay until host reads
// - Summary event bit high when any flag
// - Flag bit1 pin b, bit0 pin a, inputs
// - Lock bit makes lockable registers read-only
// - Lock holds until hard reset only
// - Lock register itself cannot be cleared
// - Lock resets zero; writes accepted while clear
// - Feature register reports three-bit shutdown code
// - Codes 000 to 010 select diode modes
// - Codes 011 to 101 select further modes
// - Product code differs by channel variant
// - Fixed eight-bit maker code readable
// - Fixed eight-bit die revision readable
// - Direction bit: 0 input, 1 output
`default_nettype none
package gal_pkg;
	localparam logic [7:0] GAL_IDX_DIR = 8'hE1;
	localparam logic [7:0] GAL_IDX_ALERT_EN = 8'hE5;
	localparam logic [7:0] GAL_IDX_FLAGS = 8'hE6;
	localparam logic [7:0] GAL_IDX_LOCK = 8'hEF;
	localparam logic [7:0] GAL_IDX_FEAT = 8'hFC;
	localparam logic [7:0] GAL_IDX_PART = 8'hFD;
	localparam logic [7:0] GAL_IDX_MAKER = 8'hFE;
	localparam logic [7:0] GAL_IDX_REV = 8'hFF;
	localparam int GAL_BIT_PIN_A = 0;
	localparam int GAL_BIT_PIN_B = 1;
	localparam int GAL_BIT_LOCK = 0;
	localparam logic [1:0] GAL_RST_DIR = 2'h0;
	localparam logic [1:0] GAL_RST_ALERT_EN = 2'h0;
	localparam logic [1:0] GAL_RST_FLAGS = 2'h0;
	localparam logic GAL_RST_LOCK = 1'b0;
	localparam logic [7:0] GAL_PART_SINGLE = 8'hA1;
	localparam logic [7:0] GAL_PART_MULTI = 8'hA2;
	localparam logic [7:0] GAL_MAKER_CODE = 8'hC3;
	localparam logic [7:0] GAL_REV_CODE = 8'h07;
	typedef enum logic [2:0] {
		GAL_SD_EXT1_SIMPLE = 3'b000,
		GAL_SD_EXT1_DIODE = 3'b001,
		GAL_SD_EXT1_TRAN = 3'b010,
		GAL_SD_INT_TRAN = 3'b011,
		GAL_SD_EXT2_TRAN = 3'b100,
		GAL_SD_EXT1_TRAN_B = 3'b101
	} gal_sd_code_t;
endpackage : gal_pkg
`default_nettype wire

// *** tb/gal_pin_model.sv ***
`default_nettype none
// Far-side pin driver: each toggle request flips its pin at the next clock edge.
module gal_pin_model (
	input wire logic mclk,
	input wire logic tog_a,
	input wire logic tog_b,
	output logic aux_pin_a,
	output logic aux_pin_b
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		aux_pin_a = 1'b0;
		aux_pin_b = 1'b0;
	end
	always @(posedge mclk) begin
		if (tog_a) aux_pin_a <= ~aux_pin_a;
		if (tog_b) aux_pin_b <= ~aux_pin_b;
	end
endmodule : gal_pin_model
`default_nettype wire

// *** tb/tb_gal_regs.sv ***
`default_nettype none
module tb_gal_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, arst_n, avs_read, avs_write, avs_waitrequest, tog_a, tog_b, aux_pin_a, aux_pin_b, alert_n, gpio_event;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, r;
	logic [1:0] avs_response;
	logic [2:0] shutdown_config_code;
	logic [31:0] exp_q [$];
	logic [7:0] idx_t [9] = '{8'hE1, 8'hE5, 8'hE6, 8'hEF, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'h10};
	logic [7:0] exp_t [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, gal_pkg::GAL_PART_MULTI, gal_pkg::GAL_MAKER_CODE,
		gal_pkg::GAL_REV_CODE, 8'h00};
	int n_mismatch = 0;
	int tests_run = 0;
	gal_regs u_gal_regs (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .aux_pin_a(aux_pin_a), .aux_pin_b(aux_pin_b),
		.shutdown_config_code(shutdown_config_code), .alert_n(alert_n), .gpio_event(gpio_event));
	gal_pin_model u_gal_pin_model (.mclk(mclk), .tog_a(tog_a), .tog_b(tog_b), .aux_pin_a(aux_pin_a),
		.aux_pin_b(aux_pin_b));
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// The request is held until waitrequest is sampled low at a rising edge.
	task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d);
		@(posedge mclk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_read <= ~w;
		avs_write <= w;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		exp_q.push_back(exp);
		bus(idx, 1'b0, 8'h00);
	endtask : rd
	task automatic tgl(input logic a, input logic b);
		@(posedge mclk);
		tog_a <= a;
		tog_b <= b;
		@(posedge mclk);
		tog_a <= 1'b0;
		tog_b <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask : tgl
	always @(posedge mclk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
	end
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (5000) @(posedge mclk);
		n_mismatch++;
		end_of_test();
	end
	initial begin
		{arst_n, avs_read, avs_write, tog_a, tog_b, avs_address, avs_writedata, shutdown_config_code} = '0;
		void'($urandom(32'h2e11edf8));
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		for (int i = 0; i < 9; i++) rd(idx_t[i], {24'h0, exp_t[i]});
		check(avs_response, 32'h3);
		for (int c = 0; c < 6; c++) begin
			shutdown_config_code <= 3'(c);
			repeat (3) @(posedge mclk);
			rd(gal_pkg::GAL_IDX_FEAT, {29'h0, 3'(c)});
		end
		check(avs_response, 32'h0);
		tgl(1'b1, 1'b0);
		tgl(1'b1, 1'b0);
		check(alert_n, 1'b1);
		check(gpio_event, 1'b1);
		rd(gal_pkg::GAL_IDX_FLAGS, 32'h1);
		rd(gal_pkg::GAL_IDX_FLAGS, 32'h0);
		@(posedge mclk);
		check(gpio_event, 1'b0);
		r = $urandom;
		bus(gal_pkg::GAL_IDX_ALERT_EN, 1'b1, r[7:0]);
		rd(gal_pkg::GAL_IDX_ALERT_EN, {30'h0, r[1:0]});
		bus(gal_pkg::GAL_IDX_REV, 1'b1, r[15:8]);
		rd(gal_pkg::GAL_IDX_REV, {24'h0, gal_pkg::GAL_REV_CODE});
		bus(gal_pkg::GAL_IDX_ALERT_EN, 1'b1, 8'h01);
		tgl(1'b0, 1'b1);
		check(alert_n, 1'b1);
		rd(gal_pkg::GAL_IDX_FLAGS, 32'h2);
		tgl(1'b1, 1'b0);
		check(alert_n, 1'b0);
		rd(gal_pkg::GAL_IDX_FLAGS, 32'h1);
		bus(gal_pkg::GAL_IDX_DIR, 1'b1, 8'h02);
		bus(gal_pkg::GAL_IDX_ALERT_EN, 1'b1, 8'h03);
		tgl(1'b0, 1'b1);
		check(alert_n, 1'b1);
		rd(gal_pkg::GAL_IDX_FLAGS, 32'h0);
		bus(gal_pkg::GAL_IDX_LOCK, 1'b1, 8'h01);
		bus(gal_pkg::GAL_IDX_ALERT_EN, 1'b1, 8'h00);
		bus(gal_pkg::GAL_IDX_DIR, 1'b1, 8'h00);
		bus(gal_pkg::GAL_IDX_LOCK, 1'b1, 8'h00);
		rd(gal_pkg::GAL_IDX_ALERT_EN, 32'h3);
		rd(gal_pkg::GAL_IDX_DIR, 32'h2);
		rd(gal_pkg::GAL_IDX_LOCK, 32'h1);
		arst_n <= 1'b0;
		repeat (5) @(posedge mclk);
		arst_n <= 1'b1;
		rd(gal_pkg::GAL_IDX_LOCK, 32'h0);
		bus(gal_pkg::GAL_IDX_ALERT_EN, 1'b1, 8'h02);
		rd(gal_pkg::GAL_IDX_ALERT_EN, 32'h2);
		end_of_test();
	end
endmodule : tb_gal_regs
`default_nettype wire
